/* File: core/light_curtain_eval.sv */
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
// Function
// RULE1 - blockage beyond settings turns both outputs off
// RULE2 - reduced resolution tolerates adjacent blocked pairs
// RULE3 - reduced resolution flashes green status
// RULE4 - blanked regions separated by unblanked beam
// RULE5 - sync beam never blanked
// RULE6 - outputs on only while blanked beams blocked
// RULE7 - blanked beam clearing causes lockout
// RULE8 - blanked zones flash green
// RULE9 - operator sets mismatched teach switch pattern
// RULE10 - teach entered on power-up or valid reset
// RULE11 - teach shows code, count, zones, red
// RULE12 - return to normal stores blocked beams
// RULE13 - teach complete code and single flashes
// RULE14 - leave teach only after valid reset
// RULE15 - empty field teach clears blanking
// RULE16 - last receiver allows remote blanking teach
// RULE17 - trip mode red while blocked, auto green
// RULE18 - latch mode reset indicator steady then flashing
// RULE19 - zones show blocked beams red
// RULE20 - cascade trip reflected on status
// RULE21 - beam one sync, zone one red only
// RULE22 - evaluate once per complete scan
module light_curtain_eval
  import lc_pkg::*;
#(
  parameter int RST_MIN_CYCLES = RST_MIN_CYC,
  parameter int RST_MAX_CYCLES = RST_MAX_CYC,
  parameter int FLASH_CYCLES = FLASH_CYC
) (
  input wire logic CORE_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  input wire apb_req_s APB_REQ_IN,
  output apb_rsp_s APB_RSP_OUT,
  input wire logic [BEAMS-1:0] BEAMS_BLOCKED_IN,
  input wire logic SCAN_DONE_IN,
  input wire switch_s SWITCH_IN,
  input wire logic RESET_SW_IN,
  input wire logic CASCADE_TRIP_IN,
  output ind_s IND_OUT
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ****************************************
  // beam evaluation
  // ****************************************
  state_s s_q;
  state_s s_d;
  logic [BEAMS-1:0] eff;
  logic trip_raw;
  logic lost;
  logic sw_normal;
  logic sw_teach;
  logic rst_valid;
  logic [COUNT_W-1:0] nblk;
  logic flash;
  logic single;
  logic [ZONES-1:0] zblk;
  logic [ZONES-1:0] zblank;
  logic [BEAMS-1:0] open_blk;
  logic wr;
  logic rd;
  logic teach_req;
  logic teach_end;

  // blanked beams are masked off before the resolution test
  assign eff = BEAMS_BLOCKED_IN & ~s_q.blanked; // RULE22
  // a run of three blocked beams is the first thing a 2-beam hole cannot hide
  assign trip_raw = BEAMS_BLOCKED_IN[0] | (SWITCH_IN.rr_a ?
                    |(eff & (eff >> 1) & (eff >> 2)) : |eff); // RULE1 RULE2
  assign lost = |(s_q.blanked & ~BEAMS_BLOCKED_IN); // RULE6 RULE7
  assign sw_normal = (SWITCH_IN.latch_a == SWITCH_IN.latch_b) &&
                     (SWITCH_IN.rr_a == SWITCH_IN.rr_b);
  assign sw_teach = !SWITCH_IN.latch_a && SWITCH_IN.rr_a &&
                    SWITCH_IN.latch_b && !SWITCH_IN.rr_b; // RULE9
  // held between the two limits, then released
  assign rst_valid = s_q.rst_prev && !RESET_SW_IN &&
                     (s_q.rst_cnt >= CNT_W'(RST_MIN_CYCLES)) &&
                     (s_q.rst_cnt <= CNT_W'(RST_MAX_CYCLES)); // RULE10
  assign flash = s_q.phase[0];
  assign single = (s_q.phase == 2'h0);

  // blanked beams stay out of the red zones so that their zones can flash green
  assign open_blk = s_q.blocked & ~s_q.blanked; // RULE8
  genvar z;
  generate
    for (z = 0; z < ZONES; z++) begin : g_zone
      assign zblk[z] = |open_blk[z*BEAMS_PER_ZONE +: BEAMS_PER_ZONE];
      assign zblank[z] = |s_q.blanked[z*BEAMS_PER_ZONE +: BEAMS_PER_ZONE];
    end
  endgenerate

  always_comb begin
    nblk = '0;
    for (int i = 0; i < BEAMS; i++) begin
      nblk = nblk + COUNT_W'(s_q.blocked[i]);
    end
  end

  // writes land in the access phase, where pready is seen high
  assign wr = APB_REQ_IN.psel && APB_REQ_IN.penable && APB_REQ_IN.pwrite;
  assign rd = APB_REQ_IN.psel && !APB_REQ_IN.penable && !APB_REQ_IN.pwrite;
  // remote teach only where this receiver stands alone or last in a cascade
  assign teach_req = wr && (APB_REQ_IN.paddr == REG_CTRL) && s_q.remote_en &&
                     APB_REQ_IN.pwdata[CTRL_TEACH_REQ_BIT]; // RULE16
  assign teach_end = wr && (APB_REQ_IN.paddr == REG_CTRL) && s_q.remote_en &&
                     APB_REQ_IN.pwdata[CTRL_TEACH_END_BIT]; // RULE16

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    // reset switch timing, saturating just past the upper limit
    if (RESET_SW_IN) begin
      if (s_q.rst_cnt <= CNT_W'(RST_MAX_CYCLES)) begin
        s_d.rst_cnt = s_q.rst_cnt + CNT_W'(1);
      end
    end else begin
      s_d.rst_cnt = '0;
    end
    s_d.rst_prev = RESET_SW_IN;
    if (s_q.flash_cnt >= CNT_W'(FLASH_CYCLES - 1)) begin
      s_d.flash_cnt = '0;
      s_d.phase = s_q.phase + 2'h1;
    end else begin
      s_d.flash_cnt = s_q.flash_cnt + CNT_W'(1);
    end
    if (SCAN_DONE_IN) begin
      s_d.blocked = BEAMS_BLOCKED_IN; // RULE22
    end

    case (s_q.mode)
      ST_INIT: begin
        // switch pattern is sampled on the first edge after release
        if (sw_teach) begin
          s_d.mode = ST_TEACH; // RULE10
        end else if (!sw_normal) begin
          s_d.mode = ST_LOCKOUT;
        end else begin
          s_d.mode = SWITCH_IN.latch_a ? ST_LATCHED : ST_RUN;
        end
      end
      ST_RUN, ST_LATCHED: begin
        if (!sw_normal) begin
          s_d.mode = ST_LOCKOUT;
        end else if (SCAN_DONE_IN) begin
          s_d.trip = trip_raw;
          if (lost) begin
            s_d.mode = ST_LOCKOUT; // RULE7
          end else if (trip_raw && SWITCH_IN.latch_a) begin
            s_d.mode = ST_LATCHED; // RULE18
          end
        end
        if (s_q.mode == ST_LATCHED && rst_valid && !s_q.trip) begin
          s_d.mode = ST_RUN;
        end
      end
      ST_LOCKOUT: begin
        if (rst_valid) begin
          s_d.mode = sw_teach ? ST_TEACH : ST_INIT; // RULE10
        end
      end
      ST_TEACH: begin
        // a remote teach never saw the switches leave normal, so software ends it
        if ((sw_normal && !s_q.teach_remote) || teach_end) begin
          // contiguous blocked beams form one region, so any two regions
          // already have a clear beam between them; empty field clears all
          s_d.blanked = s_q.blocked & ~BEAMS'(1); // RULE4 RULE5 RULE12 RULE15
          s_d.mode = ST_TEACH_DONE;
          s_d.teach_remote = 1'b0;
        end
      end
      ST_TEACH_DONE: begin
        if (rst_valid) begin
          s_d.mode = ST_INIT; // RULE14
        end
      end
      default: s_d.mode = ST_LOCKOUT;
    endcase
    if (teach_req) begin
      s_d.mode = ST_TEACH; // RULE16
      s_d.teach_remote = 1'b1;
    end

    // ****************************************
    // indicators
    // ****************************************
    s_d.ind.safety_output_a = 1'b0;
    s_d.ind.status_green = 1'b0;
    s_d.ind.status_red = 1'b1;
    s_d.ind.reset_led = 1'b0;
    s_d.ind.zone_red = zblk; // RULE19
    s_d.ind.zone_green = ~zblk & ~(zblank & {ZONES{~flash}}); // RULE8
    s_d.ind.disp_sel = DISP_COUNT;
    s_d.ind.disp_count = nblk;
    if (s_q.blocked[0]) begin
      s_d.ind.zone_red = ZONES'(1); // RULE21
      s_d.ind.zone_green = '0;
    end
    case (s_q.mode)
      ST_RUN: begin
        s_d.ind.safety_output_a = !s_q.trip; // RULE1 RULE6 RULE17
        s_d.ind.reset_led = 1'b1;
        if (!s_q.trip && !CASCADE_TRIP_IN) begin
          s_d.ind.status_green = SWITCH_IN.rr_a ? flash : 1'b1; // RULE3 RULE17
          s_d.ind.status_red = 1'b0; // RULE20
        end
      end
      ST_LATCHED: begin
        s_d.ind.reset_led = s_q.trip ? 1'b1 : flash; // RULE18
      end
      ST_LOCKOUT: begin
        s_d.ind.status_red = single;
        s_d.ind.zone_red = '0;
        s_d.ind.zone_green = '0;
        s_d.ind.disp_sel = DISP_LOCKOUT;
      end
      ST_TEACH: begin
        s_d.ind.disp_sel = flash ? DISP_TEACH_ACTIVE : DISP_COUNT; // RULE11
      end
      ST_TEACH_DONE: begin
        s_d.ind.disp_sel = DISP_TEACH_COMPLETE; // RULE13
        s_d.ind.reset_led = single;
        s_d.ind.status_red = single;
        s_d.ind.zone_red = '0;
        s_d.ind.zone_green = zblank & {ZONES{flash}};
      end
      default: begin
        s_d.ind.status_red = 1'b1;
      end
    endcase
    // both channels come from one decision so they can never disagree
    s_d.ind.safety_output_b = s_d.ind.safety_output_a; // RULE1

    // ****************************************
    // register bus
    // ****************************************
    if (wr && APB_REQ_IN.paddr == REG_CTRL) begin
      s_d.remote_en = APB_REQ_IN.pwdata[CTRL_REMOTE_EN_BIT];
    end
    if (APB_REQ_IN.psel && !APB_REQ_IN.penable) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      case (APB_REQ_IN.paddr)
        REG_CTRL: s_d.prdata[CTRL_REMOTE_EN_BIT] = s_q.remote_en;
        REG_STATUS: s_d.prdata[7:0] = {s_q.trip, s_q.ind.safety_output_a,
                                       3'h0, s_q.mode};
        REG_BLANK: s_d.prdata[BEAMS-1:0] = s_q.blanked;
        REG_BLOCKED: s_d.prdata[BEAMS-1:0] = s_q.blocked;
        default: s_d.pslverr = 1'b1;
      endcase
      if (!rd && APB_REQ_IN.paddr != REG_CTRL) begin
        s_d.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.mode <= ST_INIT;
      s_q.remote_en <= CTRL_REMOTE_EN_RST;
      s_q.ind.status_red <= 1'b1;
    end else if (CE_IN) begin
      s_q <= s_d;
    end
  end

  assign IND_OUT = s_q.ind;
  assign APB_RSP_OUT.prdata = s_q.prdata;
  assign APB_RSP_OUT.pslverr = s_q.pslverr && APB_REQ_IN.penable;
  assign APB_RSP_OUT.pready = 1'b1;

  // ****************************************
  // checks
  // ****************************************
  property p_trip_off;
    @(posedge CORE_CLK_IN) disable iff (!rst_n)
    (CE_IN && s_q.mode == ST_RUN && SCAN_DONE_IN && trip_raw && sw_normal)
      ##1 CE_IN |=> !IND_OUT.safety_output_a;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("outputs on after trip"); // RULE1

  property p_pair;
    @(posedge CORE_CLK_IN) disable iff (!rst_n)
    IND_OUT.safety_output_a == IND_OUT.safety_output_b;
  endproperty
  a_pair: assert property (p_pair) else $error("safety outputs disagree"); // RULE1

  property p_lockout;
    @(posedge CORE_CLK_IN) disable iff (!rst_n)
    (CE_IN && s_q.mode == ST_RUN && sw_normal && SCAN_DONE_IN && lost && !teach_req)
      |=> s_q.mode == ST_LOCKOUT;
  endproperty
  a_lockout: assert property (p_lockout) else $error("no lockout on lost blank"); // RULE7

  property p_teach_store;
    @(posedge CORE_CLK_IN) disable iff (!rst_n)
    (CE_IN && s_q.mode == ST_TEACH && sw_normal && !s_q.teach_remote && !teach_req)
      |=> s_q.mode == ST_TEACH_DONE && !s_q.blanked[0];
  endproperty
  a_teach_store: assert property (p_teach_store) else $error("teach not stored"); // RULE12

  property p_teach_hold;
    @(posedge CORE_CLK_IN) disable iff (!rst_n)
    (s_q.mode == ST_TEACH_DONE && !rst_valid && !teach_req) |=> s_q.mode == ST_TEACH_DONE;
  endproperty
  a_teach_hold: assert property (p_teach_hold) else $error("left teach early"); // RULE14

  property p_teach_ind;
    @(posedge CORE_CLK_IN) disable iff (!rst_n)
    (CE_IN && s_q.mode == ST_TEACH) |=> !IND_OUT.reset_led && IND_OUT.status_red;
  endproperty
  a_teach_ind: assert property (p_teach_ind) else $error("teach indicators wrong"); // RULE11

  property p_latch_led;
    @(posedge CORE_CLK_IN) disable iff (!rst_n)
    (CE_IN && s_q.mode == ST_LATCHED && s_q.trip) |=> IND_OUT.reset_led;
  endproperty
  a_latch_led: assert property (p_latch_led) else $error("reset led not steady"); // RULE18

  property p_green_safe;
    @(posedge CORE_CLK_IN) disable iff (!rst_n)
    IND_OUT.status_green |-> IND_OUT.safety_output_a && !IND_OUT.status_red;
  endproperty
  a_green_safe: assert property (p_green_safe) else $error("green while off"); // RULE17

  property p_sync_zone;
    @(posedge CORE_CLK_IN) disable iff (!rst_n)
    (CE_IN && s_q.blocked[0] && (s_q.mode == ST_RUN || s_q.mode == ST_LATCHED))
      |=> IND_OUT.zone_red == ZONES'(1) && IND_OUT.zone_green == '0;
  endproperty
  a_sync_zone: assert property (p_sync_zone) else $error("sync zone display wrong"); // RULE21
endmodule

/* File: core/lc_pkg.sv */
package lc_pkg;
  // ****************************************
  // geometry and timing
  // ****************************************
  localparam int BEAMS = 16;
  localparam int ZONES = 8;
  localparam int BEAMS_PER_ZONE = BEAMS / ZONES;
  localparam int CNT_W = 25;
  localparam int COUNT_W = 5;
  localparam int CLK_HZ = 10_000_000;
  localparam int RST_MIN_MS = 250;
  localparam int RST_MAX_MS = 2000;
  localparam int FLASH_MS = 250;
  localparam int RST_MIN_CYC = (CLK_HZ / 1000) * RST_MIN_MS;
  localparam int RST_MAX_CYC = (CLK_HZ / 1000) * RST_MAX_MS;
  localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BLANK = 8'h08;
  localparam logic [7:0] REG_BLOCKED = 8'h0c;
  localparam int CTRL_TEACH_REQ_BIT = 0;
  localparam int CTRL_TEACH_END_BIT = 1;
  localparam int CTRL_REMOTE_EN_BIT = 2;
  localparam logic CTRL_REMOTE_EN_RST = 1'b1;

  typedef enum logic [2:0] {
    ST_INIT, ST_RUN, ST_LATCHED, ST_LOCKOUT, ST_TEACH, ST_TEACH_DONE
  } mode_e;

  typedef enum logic [1:0] {
    DISP_COUNT, DISP_TEACH_ACTIVE, DISP_TEACH_COMPLETE, DISP_LOCKOUT
  } disp_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  // position switches: 0 = trip / reduced resolution off
  typedef struct packed {
    logic latch_a;
    logic rr_a;
    logic latch_b;
    logic rr_b;
  } switch_s;

  typedef struct packed {
    logic safety_output_a;
    logic safety_output_b;
    logic status_green;
    logic status_red;
    logic reset_led;
    logic [ZONES-1:0] zone_red;
    logic [ZONES-1:0] zone_green;
    disp_e disp_sel;
    logic [COUNT_W-1:0] disp_count;
  } ind_s;

  typedef struct packed {
    mode_e mode;
    logic [BEAMS-1:0] blanked;
    logic [BEAMS-1:0] blocked;
    logic trip;
    logic [CNT_W-1:0] rst_cnt;
    logic rst_prev;
    logic [CNT_W-1:0] flash_cnt;
    logic [1:0] phase;
    logic remote_en;
    logic teach_remote;
    ind_s ind;
    logic [31:0] prdata;
    logic pslverr;
  } state_s;
endpackage

/* File: verification/lc_partner.sv */
`timescale 1ns/10ps
// ****************************************
// machine switching devices and operator reset switch
// ****************************************
module lc_partner
  import lc_pkg::*;
(
  input wire logic clk_in,
  input wire ind_s ind_in,
  output logic reset_sw_out,
  output int n_split_out
);
  initial begin
    reset_sw_out = 1'b0;
    n_split_out = 0;
  end
  // a split pair would leave one channel energised, so it is counted
  always @(posedge clk_in) begin
    if (ind_in.safety_output_a !== ind_in.safety_output_b) begin
      n_split_out <= n_split_out + 1;
    end
  end
  // closes the switch for n cycles, then reopens it
  task automatic press(input int n);
    @(posedge clk_in);
    reset_sw_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    reset_sw_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

/* File: verification/light_curtain_beam_evaluation_tb_top.sv */
`timescale 1ns/10ps
module light_curtain_beam_evaluation_tb_top
  import lc_pkg::*;
;
  logic clk;
  logic arst_n;
  apb_req_s req;
  apb_rsp_s rsp;
  logic [BEAMS-1:0] beams;
  logic scan;
  switch_s sw;
  logic rst_sw;
  logic casc;
  logic ce;
  ind_s ind;
  int n_split;
  int n_fail;
  int checked;
  int cyc;
  logic [31:0] rd;
  logic err;
  logic [1:0] seen;
  logic [3:0] fl;
  assign fl = {ind.status_green, ind.reset_led, ind.zone_green[2],
               ind.disp_sel == DISP_TEACH_ACTIVE};

  // short counts keep the reset and flash timing inside a quick run
  light_curtain_eval #(.RST_MIN_CYCLES(10), .RST_MAX_CYCLES(40), .FLASH_CYCLES(4)) DUT (
    .CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .CE_IN(ce), .APB_REQ_IN(req),
    .APB_RSP_OUT(rsp), .BEAMS_BLOCKED_IN(beams), .SCAN_DONE_IN(scan), .SWITCH_IN(sw),
    .RESET_SW_IN(rst_sw), .CASCADE_TRIP_IN(casc), .IND_OUT(ind));
  lc_partner PARTNER (.clk_in(clk), .ind_in(ind), .reset_sw_out(rst_sw),
    .n_split_out(n_split));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic mode(input mode_e m);
    apb(1'b0, REG_STATUS, 32'h0);
    check({29'h0, rd[2:0]}, {29'h0, m});
  endtask
  task automatic do_scan(input logic [15:0] b);
    @(posedge clk);
    beams <= b;
    scan <= 1'b1;
    @(posedge clk);
    scan <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic outs(input logic [1:0] e);
    check({ind.safety_output_a, ind.safety_output_b}, e);
  endtask
  // records which levels a flashing indicator took over several periods
  task automatic flash(input int b);
    seen = 2'b00;
    repeat (40) begin
      @(posedge clk);
      #1;
      seen |= fl[b] ? 2'b10 : 2'b01;
    end
  endtask
  task automatic do_reset(input switch_s s);
    @(posedge clk);
    arst_n <= 1'b0;
    sw <= s;
    beams <= '0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    arst_n = 1'b0;
    req = '0;
    beams = '0;
    scan = 1'b0;
    sw = '0;
    casc = 1'b0;
    ce = 1'b1;
    n_fail = 0;
    checked = 0;
    cyc = 0;
    do_reset(4'b0000);
    mode(ST_RUN);
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd[2], 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    check(err, 1'b1);
    apb(1'b1, REG_BLANK, 32'hffff);
    check(err, 1'b1);
    do_scan(16'h0000);
    outs(2'b11);
    flash(3);
    check(seen, 2'b10);
    beams <= 16'hffff;
    repeat (6) @(posedge clk);
    outs(2'b11);
    do_scan(16'h0020);
    outs(2'b00);
    check({ind.status_red, ind.zone_red}, {1'b1, 8'h04});
    do_scan(16'h0200);
    check(ind.zone_red, 8'h10);
    do_scan(16'h0001);
    check({ind.zone_red, ind.zone_green}, 16'h0100);
    do_scan(16'h0000);
    check({ind.status_green, ind.status_red}, 2'b10);
    // a scan offered while the clock enable is low must leave everything frozen
    ce <= 1'b0;
    do_scan(16'h0020);
    outs(2'b11);
    check(ind.zone_red, 8'h00);
    ce <= 1'b1;
    casc <= 1'b1;
    repeat (4) @(posedge clk);
    check({ind.status_red, ind.safety_output_a}, 2'b11);
    casc <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    mode(ST_RUN);
    apb(1'b1, REG_CTRL, 32'h4);
    apb(1'b1, REG_CTRL, 32'h5);
    mode(ST_TEACH);
    check({ind.reset_led, ind.status_red}, 2'b01);
    do_scan(16'h00b1);
    check(ind.disp_count, 5'h04);
    flash(0);
    check(seen, 2'b11);
    apb(1'b1, REG_CTRL, 32'h6);
    apb(1'b0, REG_BLANK, 32'h0);
    check(rd, 32'h00b0);
    mode(ST_TEACH_DONE);
    check(ind.disp_sel, DISP_TEACH_COMPLETE);
    flash(2);
    check(seen, 2'b11);
    PARTNER.press(3);
    mode(ST_TEACH_DONE);
    PARTNER.press(20);
    mode(ST_RUN);
    do_scan(16'h00b0);
    outs(2'b11);
    flash(1);
    check(seen, 2'b11);
    do_scan(16'h00b2);
    outs(2'b00);
    do_scan(16'h0090);
    mode(ST_LOCKOUT);
    outs(2'b00);
    do_reset(4'b0110);
    mode(ST_TEACH);
    do_scan(16'h0000);
    check(ind.disp_count, 5'h00);
    sw <= 4'b0000;
    repeat (4) @(posedge clk);
    mode(ST_TEACH_DONE);
    apb(1'b0, REG_BLANK, 32'h0);
    check(rd, 32'h0);
    PARTNER.press(60);
    mode(ST_TEACH_DONE);
    PARTNER.press(20);
    mode(ST_RUN);
    do_reset(4'b0101);
    do_scan(16'h0018);
    outs(2'b11);
    flash(3);
    check(seen, 2'b11);
    do_scan(16'h0038);
    outs(2'b00);
    do_scan(16'h0003);
    outs(2'b00);
    do_reset(4'b1010);
    mode(ST_LATCHED);
    PARTNER.press(20);
    do_scan(16'h0000);
    outs(2'b11);
    do_scan(16'h0100);
    flash(2);
    check(seen, 2'b10);
    do_scan(16'h0000);
    outs(2'b00);
    check(ind.status_red, 1'b1);
    flash(2);
    check(seen, 2'b11);
    PARTNER.press(20);
    do_scan(16'h0000);
    outs(2'b11);
    check(n_split, 0);
    print_verdict();
  end
endmodule
